// ---- rtl/window_watchdog_timer.sv ----
// window watchdog timer with avalon-mm register slave
`timescale 1ns/1ns
module window_watchdog_timer #(
    parameter int CNT_WIDTH = wwdt_pkg::CNT_WIDTH,
    parameter int DIV_SLOW  = wwdt_pkg::DIV_SLOW,
    parameter int DIV_FAST  = wwdt_pkg::DIV_FAST
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_CKE,
    input  wire logic        I_WAKEUP_OSCILLATOR_CLOCK,
    input  wire logic        I_WATCHDOG_DISABLE_INSTRUCTION,
    input  wire logic        I_WATCHDOG_ENABLE_INSTRUCTION,
    input  wire logic [7:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic [31:0]      O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    output logic             O_IRQ,
    output logic             O_RESET_REQ,
    output logic             O_ENABLED
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                 wu_sync1_q;
    logic                 wu_sync2_q;
    logic                 wu_prev_q;
    logic                 wu_edge;

    logic                 enabled_q;
    logic                 clksel_q;
    logic                 divsel_q;
    logic [15:0]          reload_q;
    logic [15:0]          window_q;
    logic [CNT_WIDTH-1:0] count_q;
    logic                 reset_req_q;

    logic [wwdt_pkg::EVT_WIDTH-1:0] status_q;
    logic [wwdt_pkg::EVT_WIDTH-1:0] status_d;
    logic [wwdt_pkg::EVT_WIDTH-1:0] irq_en_q;
    logic [wwdt_pkg::EVT_WIDTH-1:0] irq_clr;
    logic [wwdt_pkg::EVT_WIDTH-1:0] events;

    logic                 waitreq_q;
    logic [31:0]          rdata_q;
    logic                 irq_q;

    logic                 bus_req;
    logic                 wr_take;
    logic                 rd_accept;
    logic                 service;
    logic                 in_window;
    logic                 count_tick;
    logic                 pre_pulse;
    logic                 overflow;
    logic                 window_fault;
    logic                 service_ok;
    logic [31:0]          rd_mux;

    // ------------------------------------------------------------
    // wake-up oscillator clock synchroniser
    // ------------------------------------------------------------
    // sync1 feeds only sync2; edge detect looks at sync2 onward
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            // reset high: a clock already high at release gives no false edge
            wu_sync1_q <= 1'b1;
            wu_sync2_q <= 1'b1;
            wu_prev_q  <= 1'b1;
        end
        else if (I_CKE)
        begin
            wu_sync1_q <= I_WAKEUP_OSCILLATOR_CLOCK;
            wu_sync2_q <= wu_sync1_q;
            wu_prev_q  <= wu_sync2_q;
        end
    end

    assign wu_edge = wu_sync2_q && !wu_prev_q;

    assign count_tick = enabled_q && (clksel_q ? wu_edge : 1'b1);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait cycle per access; the answer is taken on the second edge
    assign bus_req   = I_AVS_READ || I_AVS_WRITE;
    assign wr_take   = I_AVS_WRITE && !waitreq_q;
    assign rd_accept = bus_req && waitreq_q;
    assign service   = wr_take && (I_AVS_ADDRESS == wwdt_pkg::ADDR_SERVICE);

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // selectable divide ratio
    wwdt_prescaler #(
        .DIV_SLOW (DIV_SLOW),
        .DIV_FAST (DIV_FAST),
        .WIDTH    (wwdt_pkg::PRE_WIDTH)
    ) u_prescaler (
        .i_clk      (I_CLK),
        .i_rst_n    (I_RST_N),
        .i_cke      (I_CKE),
        .i_clear    (service),
        .i_tick     (count_tick),
        .i_div_fast (divsel_q),
        .o_pulse    (pre_pulse)
    );

    // ------------------------------------------------------------
    // window and overflow detection
    // ------------------------------------------------------------
    // window compare on current count
    assign in_window    = (CNT_WIDTH'(window_q) > count_q);
    assign window_fault = service && enabled_q && in_window;
    assign service_ok   = service && !window_fault;
    // wrap past all ones without service
    assign overflow     = pre_pulse && (&count_q) && !service;

    // ------------------------------------------------------------
    // enable state
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            enabled_q <= 1'b1;
        else if (I_CKE)
        begin
            // instruction control, disable wins if both
            if (I_WATCHDOG_DISABLE_INSTRUCTION)
                enabled_q <= 1'b0;
            else if (I_WATCHDOG_ENABLE_INSTRUCTION)
                enabled_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            clksel_q <= wwdt_pkg::CLKSEL_RESET;
            divsel_q <= wwdt_pkg::DIVSEL_RESET;
            reload_q <= wwdt_pkg::RELOAD_RESET;
            window_q <= wwdt_pkg::WINDOW_RESET;
        end
        else if (I_CKE && wr_take)
        begin
            unique case (I_AVS_ADDRESS)
                wwdt_pkg::ADDR_CTRL:
                begin
                    if (I_AVS_BYTEENABLE[0])
                    begin
                        clksel_q <= I_AVS_WRITEDATA[wwdt_pkg::CTRL_CLKSEL_BIT];
                        divsel_q <= I_AVS_WRITEDATA[wwdt_pkg::CTRL_DIVSEL_BIT];
                    end
                end
                wwdt_pkg::ADDR_RELOAD:
                    reload_q <= merge16(reload_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                wwdt_pkg::ADDR_WINDOW:
                    window_q <= merge16(window_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            count_q <= CNT_WIDTH'(wwdt_pkg::RELOAD_RESET);
        else if (I_CKE)
        begin
            if (service_ok)
                count_q <= CNT_WIDTH'(reload_q);
            else if (pre_pulse)
                count_q <= count_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // reset request
    // ------------------------------------------------------------
    // held until the system reset it causes
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            reset_req_q <= 1'b0;
        else if (I_CKE)
        begin
            if (overflow || window_fault)
                reset_req_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // event status and interrupt
    // ------------------------------------------------------------
    always_comb
    begin
        events = '0;
        events[wwdt_pkg::EVT_OVERFLOW_BIT] = overflow;
        events[wwdt_pkg::EVT_WINDOW_BIT]   = window_fault;
        events[wwdt_pkg::EVT_SERVICE_BIT]  = service_ok;
        irq_clr = '0;
        if (wr_take && (I_AVS_ADDRESS == wwdt_pkg::ADDR_IRQ_CLEAR) && I_AVS_BYTEENABLE[0])
            irq_clr = I_AVS_WRITEDATA[wwdt_pkg::EVT_WIDTH-1:0];
        // a new event beats a simultaneous clear
        status_d = (status_q & ~irq_clr) | events;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            status_q <= '0;
        else if (I_CKE)
            status_q <= status_d;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            irq_en_q <= '0;
        else if (I_CKE && wr_take && (I_AVS_ADDRESS == wwdt_pkg::ADDR_IRQ_ENABLE)
                 && I_AVS_BYTEENABLE[0])
            irq_en_q <= I_AVS_WRITEDATA[wwdt_pkg::EVT_WIDTH-1:0];
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            irq_q <= 1'b0;
        else if (I_CKE)
            irq_q <= |(status_d & irq_en_q);
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unmapped and write-only addresses read as zero
    always_comb
    begin
        rd_mux = '0;
        unique case (I_AVS_ADDRESS)
            wwdt_pkg::ADDR_CTRL:
            begin
                rd_mux[wwdt_pkg::CTRL_CLKSEL_BIT]  = clksel_q;
                rd_mux[wwdt_pkg::CTRL_DIVSEL_BIT]  = divsel_q;
                rd_mux[wwdt_pkg::CTRL_ENABLED_BIT] = enabled_q;
            end
            wwdt_pkg::ADDR_RELOAD:
                rd_mux[15:0] = reload_q;
            wwdt_pkg::ADDR_WINDOW:
                rd_mux[15:0] = window_q;
            wwdt_pkg::ADDR_COUNT:
                rd_mux[CNT_WIDTH-1:0] = count_q;
            wwdt_pkg::ADDR_STATUS:
                rd_mux[wwdt_pkg::EVT_WIDTH-1:0] = status_q;
            wwdt_pkg::ADDR_IRQ_ENABLE:
                rd_mux[wwdt_pkg::EVT_WIDTH-1:0] = irq_en_q;
            default:
                rd_mux = '0;
        endcase
    end

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            waitreq_q <= 1'b1;
        else if (I_CKE)
            waitreq_q <= !rd_accept;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            rdata_q <= '0;
        else if (I_CKE && rd_accept)
            rdata_q <= I_AVS_READ ? rd_mux : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_AVS_READDATA    = rdata_q;
    assign O_AVS_WAITREQUEST = waitreq_q;
    assign O_IRQ             = irq_q;
    assign O_RESET_REQ       = reset_req_q;
    assign O_ENABLED         = enabled_q;

endmodule

// ---- rtl/wwdt_pkg.sv ----
// constants for the window watchdog timer
package wwdt_pkg;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_RELOAD     = 8'h04;
    localparam logic [7:0] ADDR_WINDOW     = 8'h08;
    localparam logic [7:0] ADDR_SERVICE    = 8'h0c;
    localparam logic [7:0] ADDR_COUNT      = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_CLKSEL_BIT  = 0;  // 1: wake-up oscillator clock
    localparam int CTRL_DIVSEL_BIT  = 1;  // 1: divide by 256
    localparam int CTRL_ENABLED_BIT = 2;  // read only: watchdog running

    localparam int EVT_OVERFLOW_BIT = 0;
    localparam int EVT_WINDOW_BIT   = 1;
    localparam int EVT_SERVICE_BIT  = 2;
    localparam int EVT_WIDTH        = 3;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int CNT_WIDTH = 16;
    localparam int PRE_WIDTH = 14;

    localparam logic [15:0] RELOAD_RESET = 16'hfffc;
    localparam logic [15:0] WINDOW_RESET = 16'h0000;
    localparam logic        CLKSEL_RESET = 1'b1;
    localparam logic        DIVSEL_RESET = 1'b0;

    // ------------------------------------------------------------
    // prescaler ratios and timing
    // ------------------------------------------------------------
    localparam int DIV_SLOW = 16384;
    localparam int DIV_FAST = 256;

    localparam int SYS_CLK_HZ  = 100_000_000;
    localparam int WAKEUP_HZ   = 500_000;
    // default interval, microseconds: 4 ticks * 16384 / 500 kHz is 131072, rounded to 130000
    localparam int DEFAULT_INTERVAL_US = 130_000;

endpackage

// ---- rtl/wwdt_prescaler.sv ----
// prescaler that divides the selected count clock by one of two ratios
`timescale 1ns/1ns
module wwdt_prescaler #(
    parameter int DIV_SLOW = 16384,
    parameter int DIV_FAST = 256,
    parameter int WIDTH    = 14
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_cke,
    input  wire logic i_clear,
    input  wire logic i_tick,
    input  wire logic i_div_fast,
    output logic      o_pulse
);

    localparam logic [WIDTH-1:0] LAST_SLOW = WIDTH'(DIV_SLOW - 1);
    localparam logic [WIDTH-1:0] LAST_FAST = WIDTH'(DIV_FAST - 1);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] last;
    logic             wrap;

    assign last    = i_div_fast ? LAST_FAST : LAST_SLOW;
    assign wrap    = i_tick && (cnt_q >= last);
    assign o_pulse = wrap && !i_clear;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // a change to the fast ratio mid-period ends the period early; a change to slow lengthens it
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            cnt_q <= '0;
        else if (i_cke)
        begin
            if (i_clear || wrap)
                cnt_q <= '0;
            else if (i_tick)
                cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule

// ---- testbench/test_window_watchdog_timer.sv ----
// self-checking bench for the window watchdog timer
`timescale 1ns/1ns
module test_window_watchdog_timer;
    logic        clk;
    logic        rst_n;
    logic        cke;
    logic        wu_clk;
    logic [3:0]  wu_div;
    logic        dis_i;
    logic        ena_i;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        waitreq;
    logic        irq;
    logic        rst_req;
    logic        enabled;
    int          fail_count;
    int          checks_done;
    int          n;

    window_watchdog_timer #(.DIV_SLOW(16), .DIV_FAST(4)) i_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_CKE(cke), .I_WAKEUP_OSCILLATOR_CLOCK(wu_clk),
        .I_WATCHDOG_DISABLE_INSTRUCTION(dis_i), .I_WATCHDOG_ENABLE_INSTRUCTION(ena_i),
        .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .O_IRQ(irq), .O_RESET_REQ(rst_req), .O_ENABLED(enabled));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // wake-up clock at one eighth of the system clock
    always @(posedge clk)
    begin
        wu_div <= wu_div + 4'h1;
        wu_clk <= wu_div[2];
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic test_done();
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one idle edge first, so no strobe is driven twice in one step
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= is_wr;
        rd <= !is_wr;
        @(posedge clk);
        while (waitreq !== 1'b0)
        begin
            k++;
            if (k > 50)
            begin
                fail_count++;
                test_done();
            end
            @(posedge clk);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wait_req(input int max);
        n = 0;
        while (rst_req !== 1'b1)
        begin
            @(posedge clk);
            n++;
            if (n > max)
            begin
                fail_count++;
                test_done();
            end
        end
    endtask

    task automatic pulse(input logic d, input logic e);
        @(posedge clk);
        dis_i <= d;
        ena_i <= e;
        @(posedge clk);
        dis_i <= 1'b0;
        ena_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_defaults();
        do_reset();
        check("enabled", enabled, 1'b1);
        // 4 pulses of 16 ticks, one tick per 8 cycles
        wait_req(800);
        check("default interval", n >= 500 && n <= 530, 1'b1);
        bus(0, wwdt_pkg::ADDR_CTRL, 0);
        check("ctrl", q, 32'h5);
        bus(0, wwdt_pkg::ADDR_RELOAD, 0);
        check("reload", q, 32'hfffc);
        bus(0, wwdt_pkg::ADDR_STATUS, 0);
        check("status", q, 32'h1);
        bus(0, 8'h20, 0);
        check("unmapped", q, 32'h0);
    endtask

    task automatic s_div(input logic fast);
        int exp;
        exp = fast ? 64 : 256;
        do_reset();
        bus(1, wwdt_pkg::ADDR_RELOAD, 32'hfff0);
        bus(1, wwdt_pkg::ADDR_CTRL, {30'h0, fast, 1'b0});
        bus(1, wwdt_pkg::ADDR_SERVICE, 0);
        wait_req(600);
        check("interval", n >= exp - 1 && n <= exp + 3, 1'b1);
    endtask

    task automatic s_window();
        do_reset();
        bus(1, wwdt_pkg::ADDR_WINDOW, 32'hfff8);
        bus(1, wwdt_pkg::ADDR_RELOAD, 32'hfff0);
        bus(1, wwdt_pkg::ADDR_CTRL, 32'h2);
        bus(1, wwdt_pkg::ADDR_SERVICE, 0);
        check("legal refresh", rst_req, 1'b0);
        // count now below the boundary: refresh is illegal
        bus(1, wwdt_pkg::ADDR_SERVICE, 0);
        wait_req(10);
        bus(0, wwdt_pkg::ADDR_STATUS, 0);
        check("window status", q, 32'h6);
    endtask

    task automatic s_disable();
        do_reset();
        pulse(1, 0);
        check("disabled", enabled, 1'b0);
        bus(1, wwdt_pkg::ADDR_CTRL, 32'h2);
        bus(1, wwdt_pkg::ADDR_RELOAD, 32'hfff0);
        bus(1, wwdt_pkg::ADDR_SERVICE, 0);
        repeat (200) @(posedge clk);
        check("no request", rst_req, 1'b0);
        bus(0, wwdt_pkg::ADDR_COUNT, 0);
        check("frozen count", q, 32'hfff0);
        pulse(0, 1);
        check("re-enabled", enabled, 1'b1);
        wait_req(100);
        check("resumed", n >= 58 && n <= 68, 1'b1);
    endtask

    task automatic s_irq();
        do_reset();
        bus(1, wwdt_pkg::ADDR_IRQ_ENABLE, 32'h4);
        check("irq idle", irq, 1'b0);
        bus(1, wwdt_pkg::ADDR_SERVICE, 0);
        repeat (3) @(posedge clk);
        check("irq service", irq, 1'b1);
        bus(1, wwdt_pkg::ADDR_IRQ_ENABLE, 0);
        repeat (3) @(posedge clk);
        check("irq masked", irq, 1'b0);
        bus(1, wwdt_pkg::ADDR_IRQ_ENABLE, 32'h4);
        repeat (3) @(posedge clk);
        check("irq unmasked", irq, 1'b1);
        bus(1, wwdt_pkg::ADDR_IRQ_CLEAR, 32'h4);
        repeat (3) @(posedge clk);
        check("irq cleared", irq, 1'b0);
        bus(0, wwdt_pkg::ADDR_STATUS, 0);
        check("status cleared", q, 32'h0);
    endtask

    task automatic s_freeze();
        do_reset();
        bus(1, wwdt_pkg::ADDR_RELOAD, 32'hfff0);
        bus(1, wwdt_pkg::ADDR_CTRL, 32'h2);
        // 64-cycle interval, serviced every 43 cycles
        repeat (4)
        begin
            bus(1, wwdt_pkg::ADDR_SERVICE, 0);
            repeat (40) @(posedge clk);
        end
        check("serviced in time", rst_req, 1'b0);
        bus(1, wwdt_pkg::ADDR_SERVICE, 0);
        @(posedge clk);
        cke <= 1'b0;
        repeat (100) @(posedge clk);
        check("frozen", rst_req, 1'b0);
        cke <= 1'b1;
        wait_req(100);
        check("thawed interval", n >= 62 && n <= 66, 1'b1);
    endtask

    initial
    begin
        rst_n = 1'b0;
        cke = 1'b1;
        wu_clk = 1'b0;
        wu_div = 4'h0;
        dis_i = 1'b0;
        ena_i = 1'b0;
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        fail_count = 0;
        checks_done = 0;
        s_defaults();
        s_div(1'b0);
        s_div(1'b1);
        s_window();
        s_disable();
        s_irq();
        s_freeze();
        test_done();
    end
endmodule

// ---- testbench/wwdt_asserts.sv ----
// port assertions for the window watchdog timer
`timescale 1ns/1ns
module wwdt_check (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CKE,
    input wire logic I_WATCHDOG_DISABLE_INSTRUCTION,
    input wire logic I_WATCHDOG_ENABLE_INSTRUCTION,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_RESET_REQ,
    input wire logic O_ENABLED
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    a_wait_answer: assert property (I_CKE && (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
        |=> !O_AVS_WAITREQUEST) else $error("waitrequest did not drop");
    a_wait_single: assert property (I_CKE && !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!I_AVS_READ && !I_AVS_WRITE && O_AVS_WAITREQUEST
        |=> O_AVS_WAITREQUEST) else $error("waitrequest dropped without request");
    a_reset_enabled: assert property ($rose(I_RST_N) |-> O_ENABLED && !O_RESET_REQ)
        else $error("not enabled after reset");
    a_req_sticky: assert property (O_RESET_REQ |=> O_RESET_REQ)
        else $error("reset request dropped");
    a_disable_instr: assert property (I_CKE && I_WATCHDOG_DISABLE_INSTRUCTION |=> !O_ENABLED)
        else $error("disable ignored");
    a_enable_instr: assert property (I_CKE && I_WATCHDOG_ENABLE_INSTRUCTION
        && !I_WATCHDOG_DISABLE_INSTRUCTION |=> O_ENABLED) else $error("enable ignored");
    a_enable_hold: assert property (!I_WATCHDOG_ENABLE_INSTRUCTION
        && !I_WATCHDOG_DISABLE_INSTRUCTION |=> $stable(O_ENABLED)) else $error("enable moved");
    a_quiet_disabled: assert property (!O_ENABLED ##1 (!O_ENABLED && !O_RESET_REQ)
        |=> !O_RESET_REQ) else $error("reset request while disabled");
endmodule

bind window_watchdog_timer wwdt_check i_check (.*);
